// *** olpw_arm_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
// decides whether a go write is a valid activation
module olpw_arm_detect
	import olpw_pkg::*;
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	// instruction events
	input  wire logic i_instr_done,
	input  wire logic i_ctrl_wr,
	input  wire logic i_arm_wdata,
	input  wire logic i_go_wdata,
	input  wire logic i_arm_now,
	input  wire logic i_busy,
	// result
	output logic      o_start
);
	logic armed_last_r;
	logic armed_last_nxt;

	// only an instruction that raised arm alone makes the next one eligible
	assign armed_last_nxt = i_ctrl_wr & i_arm_wdata & ~i_go_wdata & ~i_arm_now;

	// arm and go raised from zero in one write never start; go must follow arm directly
	assign o_start = i_ctrl_wr & i_go_wdata & i_arm_wdata & i_arm_now & armed_last_r
		& ~i_busy; // [RULE8] [RULE9] [RULE10] [RULE6]

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			armed_last_r <= 1'b0;
		end else if (i_ce && i_instr_done) begin
			armed_last_r <= armed_last_nxt;
		end
	end
endmodule
`default_nettype wire

// *** olpw_burn_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// guards a burn against an array that never answers
module olpw_burn_timer
	import olpw_pkg::*;
#(
	parameter int TIMEOUT_CYC = OLPW_TIMEOUT_CYC
)
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	// control
	input  wire logic i_run,
	// result
	output logic      o_expired
);
	localparam int CW = $clog2(TIMEOUT_CYC + 1);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	assign o_expired = (cnt_r == CW'(TIMEOUT_CYC));
	assign cnt_nxt   = i_run ? (o_expired ? cnt_r : cnt_r + CW'(1)) : '0;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= '0;
		end else if (i_ce) begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule
`default_nettype wire

// *** olpw_otp_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// otp array: burns after LAT cycles, answers a read one cycle later
module olpw_otp_model
	import olpw_pkg::*;
#(
	parameter int LAT = 20
)
(
	// clock and reset
	input	wire logic			i_clk,
	input	wire logic			i_rst,
	// array side of the block
	input	wire olpw_array_req_type	i_req,
	output	logic				o_done,
	output	logic				o_rvalid,
	output	logic [OLPW_WORD_W-1:0]		o_rdata
);
	logic [OLPW_WORD_W-1:0]	mem [2048];
	int			cnt_r;
	// done lasts one cycle because the count moves past LAT on the next edge, even with prog held
	assign o_done = i_req.prog && cnt_r == LAT;
	initial foreach (mem[i]) mem[i] = '0;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= 0;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
		end else begin
			cnt_r <= i_req.prog ? cnt_r + 1 : 0;
			o_rvalid <= i_req.read;
			// stale data is inverted so a late sample cannot match
			o_rdata <= i_req.read ? mem[i_req.addr] : ~o_rdata;
			if (o_done) mem[i_req.addr] <= i_req.data;
		end
	end
endmodule
`default_nettype wire

// *** olpw_pkg.sv ***
package olpw_pkg;

	// special-register addresses in the data-memory map
	localparam logic [7:0] OLPW_ADDR_TABLE_POINTER   = 8'h07;
	localparam logic [7:0] OLPW_ADDR_TABLE_HIGH_BYTE = 8'h08;
	localparam logic [7:0] OLPW_ADDR_BURN_CONTROL    = 8'h2D;
	localparam logic [7:0] OLPW_ADDR_BURN_DATA_LOW   = 8'h2E;
	localparam logic [7:0] OLPW_ADDR_BURN_DATA_HIGH  = 8'h2F;

	// burn_control field positions
	localparam int OLPW_BIT_PROGRAM_ARM = 3;
	localparam int OLPW_BIT_CYCLE_GO    = 2;

	// widths and reset values
	localparam int          OLPW_WORD_W   = 15;
	localparam int          OLPW_HIGH_W   = 7;
	localparam logic [7:0]  OLPW_RST_BYTE = 8'h00;
	localparam logic [6:0]  OLPW_RST_HIGH = 7'h00;
	localparam logic [7:0]  OLPW_READ_NONE = 8'h00;

	// last page of program memory: page number placed above table_pointer
	localparam logic [2:0]  OLPW_LAST_PAGE = 3'h7;

	// programming timeout guard, in microseconds, and its cycle count at 100 MHz
	localparam int OLPW_CLK_MHZ      = 100;
	localparam int OLPW_TIMEOUT_US   = 2000;
	localparam int OLPW_TIMEOUT_CYC  = OLPW_TIMEOUT_US * OLPW_CLK_MHZ;

	// register-port request from the cpu
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} olpw_reg_req_type;

	// request to the otp array
	typedef struct packed {
		logic                   prog;
		logic                   read;
		logic [10:0]            addr;
		logic [OLPW_WORD_W-1:0] data;
	} olpw_array_req_type;

	typedef enum logic [2:0] {
		OLPW_IDLE  = 3'b001,
		OLPW_BURN  = 3'b010,
		OLPW_FAIL  = 3'b100
	} olpw_state_type;

endpackage

// *** olpw_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE1] word held as low byte in data low, bits 14..8 in data high
// [RULE2] data high bit 7 reads zero
// [RULE3] control bits 7..4 and 1..0 read zero; arm and go reset zero
// [RULE4] program sets arm before requesting a burn
// [RULE5] both arm and go clear in hardware when a burn ends
// [RULE6] no burn starts while arm is zero
// [RULE7] writing go starts a burn; go reads one while pending
// [RULE8] go write ignored unless arm was already set
// [RULE9] arm and go set together never start a burn
// [RULE10] go must be written in the instruction right after arm
// [RULE11] cpu stalls after valid start, resumes when burn ends
// [RULE12] burn writes data registers at table pointer address
// [RULE13] program clears global interrupt enable around the sequence
// [RULE14] program ensures slow clock stable before a burn
// [RULE15] idle or sleep during a burn makes it fail; code sets no failed flag if done arrives in that same cycle
// [RULE16] read op: low byte to cpu, high bits to table high byte
// [RULE17] program polls go until zero before other operations
// [RULE18] program keeps arm clear when not writing
// [RULE19] program may read back burned words to verify
// [RULE20] burns go only to the last page, written once
// [RULE21] table high byte is read-only; unused bits read zero
// [RULE22] stall held from valid start until array signals done; code also drops it on power-down or timeout
// [RULE23] data registers and table pointer frozen during a burn
module olpw_top
	import olpw_pkg::*;
#(
	parameter int TIMEOUT_CYC = OLPW_TIMEOUT_CYC
)
(
	// clock, reset, enable
	input  wire logic               I_CLOCK,
	input  wire logic               I_SYS_RST,
	input  wire logic               I_CE,
	// cpu special-register port
	input  wire olpw_reg_req_type   I_REG_REQ,
	input  wire logic               I_INSTR_DONE,
	output logic [7:0]              O_REG_RDATA,
	// table read instruction
	input  wire logic               I_TABLE_READ,
	output logic                    O_TABLE_READ_DONE,
	output logic [7:0]              O_TABLE_LOW_BYTE,
	// cpu control
	output logic                    O_CPU_STALL,
	input  wire logic               I_POWER_DOWN,
	// otp array
	output olpw_array_req_type      O_ARRAY_REQ,
	input  wire logic               I_ARRAY_DONE,
	input  wire logic               I_ARRAY_RVALID,
	input  wire logic [OLPW_WORD_W-1:0] I_ARRAY_RDATA,
	output logic                    O_BURN_FAILED
);
	olpw_state_type state_r;
	olpw_state_type state_nxt;

	logic [7:0]              tblp_r;
	logic [7:0]              tblp_nxt;
	logic [7:0]              data_low_r;
	logic [7:0]              data_low_nxt;
	logic [OLPW_HIGH_W-1:0]  data_high_r;
	logic [OLPW_HIGH_W-1:0]  data_high_nxt;
	logic [OLPW_HIGH_W-1:0]  table_high_byte_r;
	logic                    arm_r;
	logic                    arm_nxt;
	logic                    go_r;
	logic                    go_nxt;
	logic                    read_pend_r;
	logic [7:0]              low_byte_r;
	logic                    read_done_r;
	logic                    failed_r;
	logic                    failed_nxt;

	wire wr_tblp  = I_REG_REQ.wr && I_REG_REQ.addr == OLPW_ADDR_TABLE_POINTER;
	wire wr_ctrl  = I_REG_REQ.wr && I_REG_REQ.addr == OLPW_ADDR_BURN_CONTROL;
	wire wr_low   = I_REG_REQ.wr && I_REG_REQ.addr == OLPW_ADDR_BURN_DATA_LOW;
	wire wr_high  = I_REG_REQ.wr && I_REG_REQ.addr == OLPW_ADDR_BURN_DATA_HIGH;
	wire arm_wd   = I_REG_REQ.wdata[OLPW_BIT_PROGRAM_ARM];
	wire go_wd    = I_REG_REQ.wdata[OLPW_BIT_CYCLE_GO];
	wire burning  = (state_r == OLPW_BURN);
	wire start;
	wire expired;
	wire burn_end;

	olpw_arm_detect u_arm (
		.i_clk        (I_CLOCK),
		.i_rst        (I_SYS_RST),
		.i_ce         (I_CE),
		.i_instr_done (I_INSTR_DONE),
		.i_ctrl_wr    (wr_ctrl),
		.i_arm_wdata  (arm_wd),
		.i_go_wdata   (go_wd),
		.i_arm_now    (arm_r),
		.i_busy       (burning),
		.o_start      (start)
	);

	olpw_burn_timer #(
		.TIMEOUT_CYC (TIMEOUT_CYC)
	) u_timer (
		.i_clk     (I_CLOCK),
		.i_rst     (I_SYS_RST),
		.i_ce      (I_CE),
		.i_run     (burning),
		.o_expired (expired)
	);

	// a burn ends on array completion, power-down, or a dead array
	assign burn_end = burning && (I_ARRAY_DONE || I_POWER_DOWN || expired);

	// stall from the start cycle through the end of the burn
	assign O_CPU_STALL = start || burning; // [RULE11] [RULE22]

	// register writes are locked out while burning
	assign tblp_nxt      = (wr_tblp && !burning) ? I_REG_REQ.wdata : tblp_r; // [RULE23]
	assign data_low_nxt  = (wr_low && !burning) ? I_REG_REQ.wdata : data_low_r; // [RULE1] [RULE23]
	assign data_high_nxt = (wr_high && !burning) ? I_REG_REQ.wdata[OLPW_HIGH_W-1:0]
		: data_high_r; // [RULE1] [RULE23]

	// go only sticks when the write is a valid activation
	assign go_nxt  = burn_end ? 1'b0 : (start ? 1'b1 : go_r); // [RULE7] [RULE5]
	assign arm_nxt = burn_end ? 1'b0
		: ((wr_ctrl && !burning) ? arm_wd : arm_r); // [RULE5] [RULE6]

	// idle, sleep or a silent array during a burn leaves a failed flag unless done arrives in that same cycle
	assign failed_nxt = start ? 1'b0
		: ((burning && (I_POWER_DOWN || expired) && !I_ARRAY_DONE) ? 1'b1 : failed_r); // [RULE15]

	always_comb begin
		case (state_r)
			OLPW_IDLE: state_nxt = start ? OLPW_BURN : OLPW_IDLE;
			OLPW_BURN: state_nxt = burn_end ? ((I_ARRAY_DONE && !I_POWER_DOWN)
				? OLPW_IDLE : OLPW_FAIL) : OLPW_BURN;
			OLPW_FAIL: state_nxt = start ? OLPW_BURN : OLPW_IDLE;
			default:   state_nxt = OLPW_IDLE;
		endcase
	end

	// array request: burn keeps asserted until done, power-down or timeout, read follows the table read input outside a burn
	always_comb begin
		O_ARRAY_REQ.prog = burning; // [RULE12]
		O_ARRAY_REQ.read = I_TABLE_READ && !burning; // [RULE16]
		O_ARRAY_REQ.addr = {OLPW_LAST_PAGE, tblp_r}; // [RULE20] [RULE12]
		O_ARRAY_REQ.data = {data_high_r, data_low_r}; // [RULE12]
	end

	// read-back mux; unmapped bits and addresses return zero
	always_comb begin
		case (I_REG_REQ.addr)
			OLPW_ADDR_TABLE_POINTER:   O_REG_RDATA = tblp_r;
			OLPW_ADDR_TABLE_HIGH_BYTE: O_REG_RDATA = {1'b0, table_high_byte_r}; // [RULE21]
			OLPW_ADDR_BURN_CONTROL:    O_REG_RDATA = {4'h0, arm_r, go_r, 2'h0}; // [RULE3] [RULE7]
			OLPW_ADDR_BURN_DATA_LOW:   O_REG_RDATA = data_low_r;
			OLPW_ADDR_BURN_DATA_HIGH:  O_REG_RDATA = {1'b0, data_high_r}; // [RULE2]
			default:                   O_REG_RDATA = OLPW_READ_NONE;
		endcase
	end

	// table read: only a read this block launched may capture array data
	wire                   read_capture  = read_pend_r && I_ARRAY_RVALID;
	wire                   read_pend_nxt = O_ARRAY_REQ.read || (read_pend_r && !I_ARRAY_RVALID);
	wire [7:0]             low_byte_nxt  = read_capture
		? I_ARRAY_RDATA[OLPW_WORD_W-OLPW_HIGH_W-1:0] : low_byte_r; // [RULE16]
	wire [OLPW_HIGH_W-1:0] table_high_byte_nxt      = read_capture
		? I_ARRAY_RDATA[OLPW_WORD_W-1:OLPW_WORD_W-OLPW_HIGH_W] : table_high_byte_r; // [RULE16] [RULE21]

	assign O_TABLE_READ_DONE = read_done_r;
	assign O_TABLE_LOW_BYTE  = low_byte_r;
	assign O_BURN_FAILED     = failed_r;

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			state_r <= OLPW_IDLE;
		end else if (I_CE) begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			tblp_r <= OLPW_RST_BYTE;
		end else if (I_CE) begin
			tblp_r <= tblp_nxt;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			data_low_r <= OLPW_RST_BYTE;
		end else if (I_CE) begin
			data_low_r <= data_low_nxt;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			data_high_r <= OLPW_RST_HIGH;
		end else if (I_CE) begin
			data_high_r <= data_high_nxt;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			arm_r <= 1'b0;
		end else if (I_CE) begin
			arm_r <= arm_nxt;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			go_r <= 1'b0;
		end else if (I_CE) begin
			go_r <= go_nxt;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			failed_r <= 1'b0;
		end else if (I_CE) begin
			failed_r <= failed_nxt;
		end
	end

	// one read outstanding; the pending flag drops with the array's answer
	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			read_pend_r <= 1'b0;
		end else if (I_CE) begin
			read_pend_r <= read_pend_nxt;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			read_done_r <= 1'b0;
		end else if (I_CE) begin
			read_done_r <= read_capture;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			low_byte_r <= OLPW_RST_BYTE;
		end else if (I_CE) begin
			low_byte_r <= low_byte_nxt;
		end
	end

	// high bits land only in the read-only register
	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			table_high_byte_r <= OLPW_RST_HIGH;
		end else if (I_CE) begin
			table_high_byte_r <= table_high_byte_nxt;
		end
	end
endmodule
`default_nettype wire

// *** olpw_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module olpw_top_sva
	import olpw_pkg::*;
(
	// clock and reset
	input	wire logic			I_CLOCK,
	input	wire logic			I_SYS_RST,
	// watched ports
	input	wire olpw_reg_req_type		I_REG_REQ,
	input	wire logic [7:0]		O_REG_RDATA,
	input	wire logic			I_POWER_DOWN,
	input	wire logic			O_CPU_STALL,
	input	wire olpw_array_req_type	O_ARRAY_REQ,
	input	wire logic			I_ARRAY_DONE,
	input	wire logic			I_ARRAY_RVALID,
	input	wire logic			O_TABLE_READ_DONE,
	input	wire logic			O_BURN_FAILED
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_SYS_RST);
	wire	prog = O_ARRAY_REQ.prog;
	wire	ctl = I_REG_REQ.addr == OLPW_ADDR_BURN_CONTROL;
	wire	go_wr = I_REG_REQ.wr && ctl && I_REG_REQ.wdata[3:2] == 2'b11;
	wire	[25:0] burn_word = {O_ARRAY_REQ.addr, O_ARRAY_REQ.data};
	AST_STALL: assert property (prog |-> O_CPU_STALL)
		else $error("stall low in burn");
	AST_START: assert property ($rose(prog) |-> $past(go_wr))
		else $error("burn without go write");
	AST_END: assert property (prog && I_ARRAY_DONE |=> !prog && !O_CPU_STALL)
		else $error("burn not ended by done");
	AST_PAGE: assert property (prog |-> O_ARRAY_REQ.addr[10:8] == OLPW_LAST_PAGE)
		else $error("burn outside last page");
	AST_FROZEN: assert property (prog && $past(prog) |-> $stable(burn_word))
		else $error("burn word moved");
	AST_CTRL_RD: assert property (ctl |-> O_REG_RDATA[7:4] == 4'h0 && O_REG_RDATA[1:0] == 2'h0)
		else $error("control spare bits set");
	AST_HIGH_RD: assert property (I_REG_REQ.addr == OLPW_ADDR_BURN_DATA_HIGH |-> !O_REG_RDATA[7])
		else $error("data high bit 7 set");
	AST_TBL: assert property (O_ARRAY_REQ.read ##1 I_ARRAY_RVALID |=> O_TABLE_READ_DONE)
		else $error("table read not done");
	AST_PWRDN: assert property (prog && I_POWER_DOWN |-> ##[1:2] O_BURN_FAILED)
		else $error("power down not failed");
	cover property ($rose(prog));
	cover property (O_TABLE_READ_DONE);
	cover property ($rose(O_BURN_FAILED));
endmodule
bind olpw_top olpw_top_sva u_sva (
	.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_REG_REQ(I_REG_REQ),
	.O_REG_RDATA(O_REG_RDATA), .I_POWER_DOWN(I_POWER_DOWN), .O_CPU_STALL(O_CPU_STALL),
	.O_ARRAY_REQ(O_ARRAY_REQ), .I_ARRAY_DONE(I_ARRAY_DONE), .I_ARRAY_RVALID(I_ARRAY_RVALID),
	.O_TABLE_READ_DONE(O_TABLE_READ_DONE), .O_BURN_FAILED(O_BURN_FAILED)
);
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb import olpw_pkg::*;;
	logic			clk, rst, trd, pdn, done, rv, tdone, stall, fail, ce, mute;
	logic [7:0]		rdata, lowb;
	logic [14:0]		ardata;
	olpw_reg_req_type	req;
	olpw_array_req_type	areq;
	int			err_count, checks_done;
	olpw_top #(.TIMEOUT_CYC(50)) dut (
		.I_CLOCK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_REG_REQ(req),
		.I_INSTR_DONE(1'b1), .O_REG_RDATA(rdata), .I_TABLE_READ(trd),
		.O_TABLE_READ_DONE(tdone), .O_TABLE_LOW_BYTE(lowb), .O_CPU_STALL(stall),
		.I_POWER_DOWN(pdn), .O_ARRAY_REQ(areq), .I_ARRAY_DONE(done & ~mute),
		.I_ARRAY_RVALID(rv), .I_ARRAY_RDATA(ardata), .O_BURN_FAILED(fail));
	olpw_otp_model #(.LAT(20)) u_otp (.i_clk(clk), .i_rst(rst), .i_req(areq),
		.o_done(done), .o_rvalid(rv), .o_rdata(ardata));
	task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		req = '{1'b0, 1'b1, a, 8'h00};
		#1 chk($sformatf("reg %h", a), rdata, exp);
		@(negedge clk);
	endtask
	// arm then go in consecutive instructions, with interrupts assumed off
	task automatic burn();
		wr(OLPW_ADDR_BURN_CONTROL, 8'h08);
		wr(OLPW_ADDR_BURN_CONTROL, 8'h0C);
		req = '0;
		@(negedge clk);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial begin
		#20000;
		err_count++;
		final_report();
	end
	initial begin
		rst = 1;
		req = '0;
		trd = 0;
		pdn = 0;
		ce = 1;
		mute = 0;
		err_count = 0;
		checks_done = 0;
		repeat (6) @(negedge clk);
		rst = 0;
		rd(OLPW_ADDR_BURN_CONTROL, 8'h00);
		rd(OLPW_ADDR_BURN_DATA_LOW, 8'h00);
		rd(8'h30, 8'h00);
		// a write seen with the clock enable low must not land
		ce = 0;
		wr(OLPW_ADDR_BURN_DATA_LOW, 8'h5A);
		ce = 1;
		rd(OLPW_ADDR_BURN_DATA_LOW, 8'h00);
		wr(OLPW_ADDR_TABLE_POINTER, 8'h06);
		wr(OLPW_ADDR_BURN_DATA_LOW, 8'hA5);
		wr(OLPW_ADDR_BURN_DATA_HIGH, 8'hFF);
		rd(OLPW_ADDR_BURN_DATA_HIGH, 8'h7F);
		wr(OLPW_ADDR_BURN_CONTROL, 8'h04);
		rd(OLPW_ADDR_BURN_CONTROL, 8'h00);
		wr(OLPW_ADDR_BURN_CONTROL, 8'h0C);
		rd(OLPW_ADDR_BURN_CONTROL, 8'h08);
		chk("stall", {7'h00, stall}, 8'h00);
		wr(OLPW_ADDR_BURN_CONTROL, 8'h00);
		// another instruction between arm and go breaks the pair
		wr(OLPW_ADDR_BURN_CONTROL, 8'h08);
		wr(OLPW_ADDR_BURN_DATA_HIGH, 8'h7F);
		wr(OLPW_ADDR_BURN_CONTROL, 8'h0C);
		rd(OLPW_ADDR_BURN_CONTROL, 8'h08);
		wr(OLPW_ADDR_BURN_CONTROL, 8'h00);
		burn();
		chk("stall", {7'h00, stall}, 8'h01);
		rd(OLPW_ADDR_BURN_CONTROL, 8'h0C);
		wr(OLPW_ADDR_BURN_DATA_LOW, 8'h11);
		req = '0;
		// polling stall until it clears, bounded well past the burn length
		repeat (100) if (stall) @(negedge clk);
		rd(OLPW_ADDR_BURN_CONTROL, 8'h00);
		rd(OLPW_ADDR_BURN_DATA_LOW, 8'hA5);
		trd = 1;
		@(negedge clk);
		trd = 0;
		repeat (10) if (!tdone) @(negedge clk);
		chk("read done", {7'h00, tdone}, 8'h01);
		chk("low byte", lowb, 8'hA5);
		rd(OLPW_ADDR_TABLE_HIGH_BYTE, 8'h7F);
		wr(OLPW_ADDR_TABLE_HIGH_BYTE, 8'h00);
		rd(OLPW_ADDR_TABLE_HIGH_BYTE, 8'h7F);
		req = '0;
		// a silent array: the guard timer ends the burn and flags it
		mute = 1;
		burn();
		repeat (100) if (stall) @(negedge clk);
		mute = 0;
		chk("stall", {7'h00, stall}, 8'h00);
		chk("failed", {7'h00, fail}, 8'h01);
		rd(OLPW_ADDR_BURN_CONTROL, 8'h00);
		req = '0;
		burn();
		chk("failed", {7'h00, fail}, 8'h00);
		pdn = 1;
		@(negedge clk);
		pdn = 0;
		repeat (3) @(negedge clk);
		chk("failed", {7'h00, fail}, 8'h01);
		chk("stall", {7'h00, stall}, 8'h00);
		rd(OLPW_ADDR_BURN_CONTROL, 8'h00);
		final_report();
	end
endmodule
`default_nettype wire
